// ### verilog/pfm_pkg.sv
// shared constants and types for the pulse frequency meter
`default_nettype none
package pfm_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_AVG     = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_RESULT  = 8'h0c;
  localparam logic [7:0] OFS_RAW     = 8'h10;
  localparam logic [7:0] OFS_PCOUNT  = 8'h14;
  // field positions
  localparam int CTRL_CMD_BIT    = 0;
  localparam int CTRL_GATE_LSB   = 1;
  localparam int CTRL_MODE_LSB   = 4;
  localparam int STAT_RUN_BIT    = 4;
  // reset values and window size limits
  localparam logic [1:0] GATE_RST = 2'h0;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [6:0] AVG_MIN  = 7'h01;
  localparam logic [6:0] AVG_MAX  = 7'h64;
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int GATE_10MS_NS  = 10_000_000;
  localparam int GATE_100MS_NS = 100_000_000;
  localparam int GATE_1S_NS    = 1_000_000_000;
  // per-gate scale to hertz
  localparam logic signed [31:0] SCALE_10MS  = 32'sh64;
  localparam logic signed [31:0] SCALE_100MS = 32'sh0a;
  localparam logic signed [31:0] SCALE_1S    = 32'sh01;
  // averaging arithmetic
  localparam int SUM_W = 40;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    GATE_10MS  = 2'b00,
    GATE_100MS = 2'b01,
    GATE_1S    = 2'b10
  } pfm_gate_t;
  typedef enum logic [2:0] {
    MODE_1P_X1  = 3'b000,
    MODE_1P_X2  = 3'b001,
    MODE_CW_CCW = 3'b010,
    MODE_2P_X1  = 3'b011,
    MODE_2P_X2  = 3'b100,
    MODE_2P_X4  = 3'b101
  } pfm_mode_t;
  typedef enum logic {
    MS_STOPPED = 1'b0,
    MS_RUNNING = 1'b1
  } pfm_meas_t;
  typedef enum logic {
    AV_IDLE   = 1'b0,
    AV_DIVIDE = 1'b1
  } pfm_avg_state_t;
endpackage
`default_nettype wire

// ### verilog/pfm_decoder.sv
// pin synchroniser and pulse-input multiplier
`default_nettype none
module pfm_decoder
  import pfm_pkg::*;
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // pins and mode
  input  wire logic       phase_a,
  input  wire logic       phase_b,
  input  wire logic [2:0] mode,
  // count strobes
  output logic            cnt_up,
  output logic            cnt_dn
);
  logic [1:0] a_sync;
  logic [1:0] b_sync;
  logic       a_prev;
  logic       b_prev;
  wire a_rise = a_sync[1] & ~a_prev;
  wire a_fall = ~a_sync[1] & a_prev;
  wire b_rise = b_sync[1] & ~b_prev;
  wire b_fall = ~b_sync[1] & b_prev;
  wire b_lvl  = b_sync[1];
  wire a_lvl  = a_sync[1];
  // quadrature direction per edge: a leading b counts up
  wire q_a_up = (a_rise & ~b_lvl) | (a_fall & b_lvl);
  wire q_a_dn = (a_rise & b_lvl) | (a_fall & ~b_lvl);
  wire q_b_up = (b_rise & a_lvl) | (b_fall & ~a_lvl);
  wire q_b_dn = (b_rise & ~a_lvl) | (b_fall & a_lvl);
  logic next_up;
  logic next_dn;
  always_comb begin
    next_up = 1'b0;
    next_dn = 1'b0;
    case (pfm_mode_t'(mode))
      MODE_1P_X1:  begin next_up = a_rise & ~b_lvl; next_dn = a_rise & b_lvl; end
      MODE_1P_X2:  begin next_up = (a_rise | a_fall) & ~b_lvl; next_dn = (a_rise | a_fall) & b_lvl; end
      MODE_CW_CCW: begin next_up = a_rise & ~b_rise; next_dn = b_rise & ~a_rise; end
      MODE_2P_X1:  begin next_up = a_rise & ~b_lvl; next_dn = a_fall & ~b_lvl; end
      MODE_2P_X2:  begin next_up = q_a_up; next_dn = q_a_dn; end
      MODE_2P_X4:  begin next_up = q_a_up | q_b_up; next_dn = q_a_dn | q_b_dn; end
      default:     begin next_up = 1'b0; next_dn = 1'b0; end
    endcase
  end
  // stage 0 of each synchroniser feeds only stage 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_sync <= 2'h0;
      b_sync <= 2'h0;
      a_prev <= 1'b0;
      b_prev <= 1'b0;
      cnt_up <= 1'b0;
      cnt_dn <= 1'b0;
    end else begin
      a_sync <= {a_sync[0], phase_a};
      b_sync <= {b_sync[0], phase_b};
      a_prev <= a_sync[1];
      b_prev <= b_sync[1];
      cnt_up <= next_up;
      cnt_dn <= next_dn;
    end
  end
  a_no_both_dirs: assert property (@(posedge aclk) disable iff (!aresetn) !(cnt_up && cnt_dn))
    else $error("up and down strobes together");
endmodule
`default_nettype wire

// ### verilog/pfm_averager.sv
// sliding-window moving average with serial divider
`default_nettype none
module pfm_averager
  import pfm_pkg::*;
#(
  parameter int MAX_N = 100
) (
  // clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // control
  input  wire logic               clear,
  input  wire logic [6:0]         win_n,
  // samples
  input  wire logic               in_valid,
  input  wire logic signed [31:0] in_data,
  output logic                    out_valid,
  output logic signed [31:0]      out_data
);
  logic signed [31:0]      hist [MAX_N];
  logic [6:0]              ptr;
  logic [6:0]              fill;
  logic signed [SUM_W-1:0] sum;
  pfm_avg_state_t          state;
  logic [SUM_W-1:0]        dvd;
  logic [7:0]              rem;
  logic [5:0]              bits;
  logic                    neg;
  wire                      full      = (fill == win_n);
  wire signed [SUM_W-1:0]   old_s     = full ? SUM_W'(hist[ptr]) : '0;
  wire signed [SUM_W-1:0]   next_sum  = sum + SUM_W'(in_data) - old_s;
  wire [6:0]                next_fill = full ? fill : fill + 7'h01;
  wire [7:0]                rem_sh    = {rem[6:0], dvd[SUM_W-1]};
  wire                      fits      = (rem_sh >= {1'b0, win_n});
  wire [SUM_W-1:0]          next_q    = {dvd[SUM_W-2:0], fits};
  // history needs no reset: fill gates every read of stale words
  always_ff @(posedge aclk) begin
    if (in_valid && !clear) begin
      hist[ptr] <= in_data;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      ptr       <= 7'h00;
      fill      <= 7'h00;
      sum       <= '0;
      state     <= AV_IDLE;
      dvd       <= '0;
      rem       <= 8'h00;
      bits      <= 6'h00;
      neg       <= 1'b0;
      out_valid <= 1'b0;
      out_data  <= 32'sh0;
    end else begin
      out_valid <= 1'b0;
      if (in_valid) begin
        sum  <= next_sum;
        fill <= next_fill;
        ptr  <= (ptr == win_n - 7'h01) ? 7'h00 : ptr + 7'h01;
        if (next_fill == win_n) begin
          state <= AV_DIVIDE;
          neg   <= next_sum[SUM_W-1];
          dvd   <= next_sum[SUM_W-1] ? SUM_W'(-next_sum) : SUM_W'(next_sum);
          rem   <= 8'h00;
          bits  <= 6'(SUM_W);
        end
      end else begin
        case (state)
          AV_IDLE: begin
            state <= AV_IDLE;
          end
          AV_DIVIDE: begin
            rem  <= fits ? rem_sh - {1'b0, win_n} : rem_sh;
            dvd  <= next_q;
            bits <= bits - 6'h01;
            if (bits == 6'h01) begin
              state     <= AV_IDLE;
              out_valid <= 1'b1;
              out_data  <= neg ? -$signed(next_q[31:0]) : $signed(next_q[31:0]);
            end
          end
          default: state <= AV_IDLE;
        endcase
      end
    end
  end
  a_avg_only_full: assert property (@(posedge aclk) disable iff (!aresetn)
    out_valid |-> (fill == win_n))
    else $error("average reported before window filled");
  // a clear during the divide resets it, so the check is dropped
  a_avg_direct: assert property (@(posedge aclk) disable iff (!aresetn || clear)
    (in_valid && win_n == 7'h01 && state == AV_IDLE) |-> ##41 (out_valid && out_data == $past(in_data, 41)))
    else $error("window of one did not pass sample through");
endmodule
`default_nettype wire

// ### verilog/pfm_top.sv
// frequency measurement channel with axi4-lite registers
//
// Overview of operation
// - averaging window accepts 1 to 100 samples; one means raw samples pass through
// - average reported only once the window holds enough samples, then every sample
// - gate time selectable among 10 ms, 100 ms and 1 s
// - raw frequency equals gate pulse count divided by gate time in seconds
// - zero pulses in a gate gives a raw frequency of exactly zero
// - net downward counting gives a negative, signed frequency
// - unaveraged resolution is 1, 10 or 100 Hz by gate
// - pulses never dropped at gate edges, so fractions carry into later gates
// - multiplied pulse-input modes count every multiplied edge
// - raising the measure command starts measuring and sets the running status bit
// - while the command holds, each new report is written to the result register
// - dropping the command stops, clears running, zeroes internal value, no result write
// - a command seen while already running is ignored, measurement continues
// - pulses on phase a are counted while running; phase b edges only in cw/ccw and 2-phase x4 modes
`default_nettype none
module pfm_top
  import pfm_pkg::*;
#(
  parameter int GATE_10MS_CYCLES  = GATE_10MS_NS / CLK_PERIOD_NS,
  parameter int GATE_100MS_CYCLES = GATE_100MS_NS / CLK_PERIOD_NS,
  parameter int GATE_1S_CYCLES    = GATE_1S_NS / CLK_PERIOD_NS,
  parameter int MAX_N             = 100
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pulse pins
  input  wire logic        phase_a,
  input  wire logic        phase_b,
  // measurement result
  output logic [31:0]      freq_value,
  output logic             freq_update,
  output logic             meas_running
);
  // clamp a written window size into the legal range
  function automatic logic [6:0] clamp_avg(input logic [7:0] v);
    if (v < {1'b0, AVG_MIN}) begin
      return AVG_MIN;
    end else if (v > {1'b0, AVG_MAX}) begin
      return AVG_MAX;
    end
    return v[6:0];
  endfunction

  // cycles per gate for a gate code; undefined code falls to 1 s
  function automatic logic [31:0] gate_cycles(input logic [1:0] g);
    case (pfm_gate_t'(g))
      GATE_10MS:  return 32'(GATE_10MS_CYCLES);
      GATE_100MS: return 32'(GATE_100MS_CYCLES);
      default:    return 32'(GATE_1S_CYCLES);
    endcase
  endfunction

  // software-visible control
  logic        freq_measure_command;
  logic [1:0]  gate_sel;
  logic [2:0]  pulse_mode;
  logic [6:0]  avg_n;
  // values latched at start so rewrites cannot disturb a running measurement
  logic [1:0]  gate_l;
  logic [2:0]  mode_l;
  logic [6:0]  avg_l;
  // measurement datapath
  pfm_meas_t          meas_state;
  logic [31:0]        gate_cnt;
  logic signed [31:0] pcount;
  logic signed [31:0] raw_count;
  logic signed [31:0] raw_freq;
  logic               raw_valid;
  logic               cnt_up;
  logic               cnt_dn;
  logic               avg_valid;
  logic signed [31:0] avg_data;
  // bus holding registers
  logic        aw_full;
  logic        w_full;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  // measurement sequencing
  wire meas_start = freq_measure_command && (meas_state == MS_STOPPED);
  wire meas_stop  = !freq_measure_command && (meas_state == MS_RUNNING);
  wire running    = (meas_state == MS_RUNNING);
  wire [31:0] gate_len  = gate_cycles(gate_l);
  wire        gate_end  = running && (gate_cnt == gate_len - 32'h1);
  wire signed [31:0] delta = cnt_up ? 32'sh1 : (cnt_dn ? -32'sh1 : 32'sh0);
  wire signed [31:0] pcount_sum = pcount + delta;
  wire signed [31:0] scale = (pfm_gate_t'(gate_l) == GATE_10MS) ? SCALE_10MS :
                             (pfm_gate_t'(gate_l) == GATE_100MS) ? SCALE_100MS : SCALE_1S;
  wire signed [63:0] raw_prod = pcount_sum * scale;
  wire [31:0] status_word = 32'(running) << STAT_RUN_BIT;

  // register access decode
  wire wr_fire   = aw_full && w_full && !s_axi_bvalid;
  wire wr_ctrl   = wr_fire && (aw_addr == OFS_CTRL) && w_strb[0];
  wire wr_avg    = wr_fire && (aw_addr == OFS_AVG) && w_strb[0];
  wire wr_mapped = (aw_addr == OFS_CTRL) || (aw_addr == OFS_AVG) || (aw_addr == OFS_STATUS) ||
                   (aw_addr == OFS_RESULT) || (aw_addr == OFS_RAW) || (aw_addr == OFS_PCOUNT);
  wire rd_fire   = s_axi_arvalid && s_axi_arready;
  wire [31:0] ctrl_word = (32'(freq_measure_command) << CTRL_CMD_BIT) |
                          (32'(gate_sel) << CTRL_GATE_LSB) | (32'(pulse_mode) << CTRL_MODE_LSB);
  logic [31:0] rd_word;
  logic        rd_ok;
  always_comb begin
    rd_word = 32'h0;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      OFS_CTRL:   rd_word = ctrl_word;
      OFS_AVG:    rd_word = 32'(avg_n);
      OFS_STATUS: rd_word = status_word;
      OFS_RESULT: rd_word = freq_value;
      OFS_RAW:    rd_word = raw_freq;
      OFS_PCOUNT: rd_word = pcount;
      default: begin
        rd_word = 32'h0;
        rd_ok   = 1'b0;
      end
    endcase
  end

  pfm_decoder u_decoder (
    .aclk    (aclk),
    .aresetn (aresetn),
    .phase_a (phase_a),
    .phase_b (phase_b),
    .mode    (mode_l),
    .cnt_up  (cnt_up),
    .cnt_dn  (cnt_dn)
  );

  pfm_averager #(
    .MAX_N (MAX_N)
  ) u_averager (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .clear     (meas_start || meas_stop),
    .win_n     (avg_l),
    .in_valid  (raw_valid),
    .in_data   (raw_freq),
    .out_valid (avg_valid),
    .out_data  (avg_data)
  );

  // write channels: address and data may come in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
    end else begin
      s_axi_awready <= !s_axi_awready && s_axi_awvalid && !aw_full && !s_axi_bvalid;
      s_axi_wready  <= !s_axi_wready && s_axi_wvalid && !w_full && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel: one read in flight, answer the cycle after acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // writable control fields; out-of-range window sizes are clamped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      freq_measure_command <= 1'b0;
      gate_sel             <= GATE_RST;
      pulse_mode           <= MODE_RST;
      avg_n                <= AVG_MIN;
    end else begin
      if (wr_ctrl) begin
        freq_measure_command <= w_data[CTRL_CMD_BIT];
        gate_sel             <= w_data[CTRL_GATE_LSB +: 2];
        pulse_mode           <= w_data[CTRL_MODE_LSB +: 3];
      end
      if (wr_avg) begin
        avg_n <= clamp_avg(w_data[7:0]);
      end
    end
  end

  // measurement state and gate timing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meas_state <= MS_STOPPED;
      gate_l     <= GATE_RST;
      mode_l     <= MODE_RST;
      avg_l      <= AVG_MIN;
      gate_cnt   <= 32'h0;
    end else begin
      if (meas_start) begin
        meas_state <= MS_RUNNING;
        gate_l     <= gate_sel;
        mode_l     <= pulse_mode;
        avg_l      <= avg_n;
        gate_cnt   <= 32'h0;
      end else if (meas_stop) begin
        meas_state <= MS_STOPPED;
        gate_cnt   <= 32'h0;
      end else if (running) begin
        gate_cnt <= gate_end ? 32'h0 : gate_cnt + 32'h1;
      end
    end
  end

  // pulse counting and raw samples
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pcount    <= 32'sh0;
      raw_count <= 32'sh0;
      raw_freq  <= 32'sh0;
      raw_valid <= 1'b0;
    end else begin
      raw_valid <= 1'b0;
      if (meas_start || meas_stop) begin
        pcount    <= 32'sh0;
        raw_count <= 32'sh0;
        raw_freq  <= 32'sh0;
      end else if (gate_end) begin
        // the strobe in the closing cycle joins this gate, so none are lost
        pcount    <= 32'sh0;
        raw_count <= pcount_sum;
        raw_freq  <= raw_prod[31:0];
        raw_valid <= 1'b1;
      end else if (running) begin
        pcount <= pcount_sum;
      end
    end
  end

  // destination register and outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      freq_value   <= 32'h0;
      freq_update  <= 1'b0;
      meas_running <= 1'b0;
    end else begin
      meas_running <= meas_start || (running && !meas_stop);
      freq_update  <= avg_valid && running && !meas_stop;
      if (avg_valid && running && !meas_stop) begin
        freq_value <= avg_data;
      end
    end
  end

  a_start_runs: assert property (@(posedge aclk) disable iff (!aresetn)
    meas_start |=> (running && meas_running && status_word[STAT_RUN_BIT]))
    else $error("start did not set running");
  a_stop_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    meas_stop |=> (!running && !meas_running && raw_freq == 32'sh0 && pcount == 32'sh0))
    else $error("stop did not clear running and value");
  a_stop_no_write: assert property (@(posedge aclk) disable iff (!aresetn)
    meas_stop |=> (!freq_update && $stable(freq_value)) ##1 (!freq_update && $stable(freq_value)))
    else $error("result written after stop");
  a_restart_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
    (running && freq_measure_command) |=> (running && $stable(gate_l) && $stable(avg_l)))
    else $error("running measurement disturbed by command");
  a_gate_sample: assert property (@(posedge aclk) disable iff (!aresetn)
    (gate_end && !meas_stop) |=> (raw_valid && raw_count == $past(pcount_sum)))
    else $error("gate end did not latch sample");
  a_zero_pulses: assert property (@(posedge aclk) disable iff (!aresetn)
    (raw_valid && raw_count == 32'sh0) |-> (raw_freq == 32'sh0))
    else $error("zero count gave nonzero frequency");
  a_neg_freq: assert property (@(posedge aclk) disable iff (!aresetn)
    (raw_valid && raw_count < 32'sh0) |-> (raw_freq < 32'sh0))
    else $error("downward count not negative");
  a_scale_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    raw_valid |-> (raw_freq == 32'(raw_count * $past(scale))))
    else $error("raw frequency scale wrong");
  a_report_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (avg_valid && running && !meas_stop) |=> (freq_update && freq_value == $past(avg_data)))
    else $error("report not written to result");
  a_status_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    meas_running == $past(status_word[STAT_RUN_BIT]) || $past(meas_start) || $past(meas_stop))
    else $error("status bit and running output disagree");
endmodule
`default_nettype wire

// ### tb/pfm_pulse_src.sv
// encoder-like pulse source driving the two phase pins
`default_nettype none
module pfm_pulse_src (
  // clock
  input  wire logic       aclk,
  // shape: cycles per step, quadrature, downward
  input  wire logic [7:0] step,
  input  wire logic       quad,
  input  wire logic       dn,
  // pins
  output logic            phase_a,
  output logic            phase_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tick = 8'h00;
  logic [1:0] ph   = 2'h0;
  logic       adv;
  // step zero parks the pins so no pulse reaches the meter
  assign adv = (step != 8'h00) && (tick + 8'h01 >= step);
  always @(posedge aclk) begin
    tick <= adv ? 8'h00 : tick + 8'h01;
    if (adv) begin
      ph <= dn ? ph - 2'h1 : ph + 2'h1;
    end
  end
  // gray order 00,10,11,01 puts a ahead of b going up
  assign phase_a = quad ? ph[1] ^ ph[0] : ph[0];
  assign phase_b = quad ? ph[1] : dn;
endmodule
`default_nettype wire

// ### tb/test_pulse_frequency_meter.sv
// self-checking bench for the frequency measurement channel
`default_nettype none
module test_pulse_frequency_meter
  import pfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0;
  logic        rready = 1'b0, quad = 1'b0, dn = 1'b0, awr, wr, bv, arr, rv, pa, pb, upd, run;
  logic [7:0]  aw = 8'h00, ar = 8'h00, step = 8'h00;
  logic [31:0] wd = 32'h0, rdata, fval, rd;
  logic [1:0]  bresp, rresp, rr;
  int          err_count = 0, checks_done = 0, cycles = 0, n;
  always #2 aclk = ~aclk;
  // short gates keep the run brief; figures below follow these lengths
  pfm_top #(.GATE_10MS_CYCLES(100), .GATE_100MS_CYCLES(200), .GATE_1S_CYCLES(400), .MAX_N(100)) pfm_top_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready), .phase_a(pa),
    .phase_b(pb), .freq_value(fval), .freq_update(upd), .meas_running(run));
  pfm_pulse_src pfm_pulse_src_i (.aclk(aclk), .step(step), .quad(quad), .dn(dn), .phase_a(pa), .phase_b(pb));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk2(input logic [31:0] got, input logic [31:0] e1, input logic [31:0] e2);
    checks_done++;
    if (got !== e1 && got !== e2) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h or %h", $time, got, e1, e2);
    end
  endtask
  // leading edge keeps a new request out of the time step of the last release
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (awv && !awr || wv && !wr);
    while (bv !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    ar <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge aclk); while (rv !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    rr = rresp;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a);
    chk(rd, e);
  endtask
  task automatic wait_upd();
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (upd !== 1'b1);
  endtask
  task automatic reg_case();
    rd_chk(OFS_AVG, 32'h1);
    axi_wr(OFS_AVG, 32'h0, RESP_OKAY);
    rd_chk(OFS_AVG, 32'h1);
    axi_wr(OFS_AVG, 32'hc8, RESP_OKAY);
    rd_chk(OFS_AVG, 32'h64);
    axi_wr(OFS_AVG, 32'h1, RESP_OKAY);
    axi_wr(8'h40, 32'h1, RESP_SLVERR);
    rd_chk(8'h40, 32'h0);
    chk(32'(rr), 32'(RESP_SLVERR));
    rd_chk(OFS_STATUS, 32'h0);
    $display("register test done");
  endtask
  task automatic stop_meas();
    axi_wr(OFS_CTRL, 32'h0, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(32'(run), 32'h0);
    rd_chk(OFS_STATUS, 32'h0);
    rd_chk(OFS_RAW, 32'h0);
    rd_chk(OFS_PCOUNT, 32'h0);
    repeat (150) @(posedge aclk);
  endtask
  task automatic run_case(input logic [2:0] m, input logic [1:0] g, input logic q, input logic d,
                          input logic [7:0] s, input logic [31:0] e);
    quad <= q;
    dn <= d;
    step <= s;
    repeat (20) @(posedge aclk);
    axi_wr(OFS_CTRL, {25'h0, m, 1'b0, g, 1'b1}, RESP_OKAY);
    wait_upd();
    chk(fval, e);
    rd_chk(OFS_RESULT, e);
    chk(32'(run), 32'h1);
    axi_wr(OFS_CTRL, {25'h0, m, 1'b0, 2'h3, 1'b1}, RESP_OKAY);
    wait_upd();
    chk(fval, e);
    rd_chk(OFS_RAW, e);
    rd_chk(OFS_CTRL, {25'h0, m, 1'b0, 2'h3, 1'b1});
    stop_meas();
    chk(fval, e);
    $display("run test done");
  endtask
  task automatic avg_case();
    step <= 8'h06;
    axi_wr(OFS_AVG, 32'h4, RESP_OKAY);
    axi_wr(OFS_CTRL, 32'h11, RESP_OKAY);
    wait_upd();
    chk(32'(n >= 400 && n <= 460), 32'h1);
    chk2(fval, 32'h672, 32'h68b);
    wait_upd();
    chk(32'(n), 32'h64);
    chk2(fval, 32'h672, 32'h68b);
    stop_meas();
    $display("averaging test done");
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    reg_case();
    run_case(MODE_1P_X1, GATE_10MS, 1'b0, 1'b0, 8'h05, 32'h3e8);
    run_case(MODE_1P_X1, GATE_10MS, 1'b0, 1'b1, 8'h05, 32'hfffffc18);
    run_case(MODE_1P_X2, GATE_10MS, 1'b0, 1'b0, 8'h05, 32'h7d0);
    run_case(MODE_CW_CCW, GATE_10MS, 1'b0, 1'b0, 8'h05, 32'h3e8);
    run_case(MODE_2P_X1, GATE_100MS, 1'b1, 1'b0, 8'h05, 32'h64);
    run_case(MODE_2P_X2, GATE_100MS, 1'b1, 1'b0, 8'h05, 32'hc8);
    run_case(MODE_2P_X4, GATE_1S, 1'b1, 1'b0, 8'h05, 32'h50);
    run_case(MODE_2P_X4, GATE_10MS, 1'b1, 1'b1, 8'h05, 32'hfffff830);
    run_case(MODE_1P_X1, GATE_10MS, 1'b0, 1'b0, 8'h00, 32'h0);
    avg_case();
    avg_case();
    finish_test();
  end
endmodule
`default_nettype wire
